// *** verilog/arc_pkg.sv ***
package arc_pkg;

   // clock and time base
   localparam int CLK_HZ            = 20_000_000;
   localparam int MS_PER_S          = 1000;
   localparam int CYC_PER_MS_DFLT   = CLK_HZ / MS_PER_S;
   localparam int SEC_PER_MIN       = 60;

   // times in their own units and in milliseconds
   localparam int RESTART_DELAY_MIN = 3;
   localparam int RESTART_MS        = RESTART_DELAY_MIN * SEC_PER_MIN * MS_PER_S;
   localparam int LONG_MIN_S        = 3;
   localparam int LONG_MIN_MS       = LONG_MIN_S * MS_PER_S;
   localparam int LONG_MAX_S        = 10;
   localparam int LONG_MAX_MS       = LONG_MAX_S * MS_PER_S;
   localparam int FLASH_S           = 5;
   localparam int FLASH_MS          = FLASH_S * MS_PER_S;
   localparam int BEEP_ON_MS        = 200;
   localparam int BEEP_OFF_MS       = 200;
   localparam int BLINK_HALF_MS     = 250;
   localparam int BEEP_COUNT        = 3;

   // counter widths
   localparam int MS_W              = 15;
   localparam int HOLD_W            = 14;
   localparam int DLY_W             = 18;
   localparam int SEQ_W             = 13;
   localparam int BLK_W             = 8;

   // apb register map
   localparam int APB_AW            = 8;
   localparam int APB_DW            = 32;
   localparam logic [APB_AW-1:0] OFS_CTRL = 8'h00;
   localparam logic [APB_AW-1:0] OFS_CFG  = 8'h04;
   localparam logic [APB_AW-1:0] OFS_STAT = 8'h08;

   // field positions
   localparam int CTRL_ON_BIT       = 0;
   localparam int CTRL_OFF_BIT      = 1;
   localparam int CTRL_TARM_BIT     = 2;
   localparam int CTRL_TCLR_BIT     = 3;
   localparam int SET_W             = 8;
   localparam int CFG_FLT_BIT       = 8;
   localparam int ST_RUN_BIT        = 0;
   localparam int ST_EN_BIT         = 1;
   localparam int ST_TMR_BIT        = 2;
   localparam int ST_PEND_BIT       = 3;
   localparam int ST_FREQ_BIT       = 4;
   localparam int ST_MAINS_BIT      = 5;
   localparam int ST_FLASH_BIT      = 6;
   localparam int ST_BEEP_BIT       = 7;

   // retained storage layout and factory contents
   localparam int NV_DW             = 16;
   localparam int NV_WORDS          = 2;
   localparam logic NV_FLAGS_ADDR   = 1'b0;
   localparam logic NV_SET_ADDR     = 1'b1;
   localparam int NV_EN_BIT         = 0;
   localparam int NV_RUN_BIT        = 1;
   localparam int NV_TMR_BIT        = 2;
   localparam logic [NV_DW-1:0] NV_FLAGS_RST = 16'h0001;
   localparam logic [NV_DW-1:0] NV_SET_RST   = 16'h0000;

   typedef enum logic [1:0] {
      PW_OFF   = 2'b00,
      PW_CHECK = 2'b01,
      PW_DELAY = 2'b10,
      PW_ON    = 2'b11
   } arc_pwr_t;

   typedef enum logic [1:0] {
      SQ_IDLE     = 2'b00,
      SQ_BEEP_ON  = 2'b01,
      SQ_BEEP_OFF = 2'b10,
      SQ_FLASH    = 2'b11
   } arc_seq_t;

   typedef enum logic [1:0] {
      RG_CTRL = 2'b00,
      RG_CFG  = 2'b01,
      RG_STAT = 2'b10,
      RG_NONE = 2'b11
   } arc_reg_t;

endpackage

// *** verilog/arc_nv_if.sv ***
interface arc_nv_if;
   import arc_pkg::*;
   logic             we;
   logic             waddr;
   logic [NV_DW-1:0] wdata;
   logic [NV_DW-1:0] rd_flags;
   logic [NV_DW-1:0] rd_set;

   modport ctl   (output we, waddr, wdata, input rd_flags, rd_set);
   modport store (input we, waddr, wdata, output rd_flags, rd_set);
endinterface

// *** verilog/arc_nv_store.sv ***
module arc_nv_store (
   input wire logic pclk,
   input wire logic factory_rst_n,
   arc_nv_if.store  nv
);
   import arc_pkg::*;

   logic [NV_DW-1:0] mem_reg [NV_WORDS];
   logic [NV_DW-1:0] rd_flags_reg;
   logic [NV_DW-1:0] rd_set_reg;

   // retained words, only the factory clear restores them
   always_ff @(posedge pclk or negedge factory_rst_n) begin
      if (!factory_rst_n) begin
         mem_reg[0] <= NV_FLAGS_RST; // see RULE1
         mem_reg[1] <= NV_SET_RST;
      end else if (nv.we) begin
         mem_reg[nv.waddr] <= nv.wdata; // see RULE16
      end
   end

   // registered read of both words
   always_ff @(posedge pclk or negedge factory_rst_n) begin
      if (!factory_rst_n) begin
         rd_flags_reg <= NV_FLAGS_RST;
         rd_set_reg   <= NV_SET_RST;
      end else begin
         rd_flags_reg <= mem_reg[NV_FLAGS_ADDR];
         rd_set_reg   <= mem_reg[NV_SET_ADDR];
      end
   end

   assign nv.rd_flags = rd_flags_reg;
   assign nv.rd_set   = rd_set_reg;
endmodule

// *** verilog/arc_auto_restart.sv ***
// Contract
// RULE1: restart feature enabled from the factory
// RULE2: enabled restart resumes after three minutes, silently
// RULE3: no resume when restart feature disabled
// RULE4: no resume if stopped at power loss
// RULE5: no resume if timer armed at loss
// RULE6: configuration changes only while mains present
// RULE7: toggle only for press 3 to 10 seconds
// RULE8: press in standby starts, white lamp on
// RULE9: press while running stops, white lamp off
// RULE10: three beeps after three seconds held
// RULE11: enabling flashes lamp five seconds after beeps
// RULE12: run state then kept until next command
// RULE13: filter lamp lit makes button filter reset
// RULE14: power loss discards armed one-shot timer
// RULE15: remote resends daily timer every thirty minutes; no remote or daily timer logic exists here
// RULE16: restart flag and settings kept in retained storage
module arc_auto_restart #(
   parameter int CYC_PER_MS = arc_pkg::CYC_PER_MS_DFLT
) (
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic                        factory_rst_n,
   input  wire logic [arc_pkg::APB_AW-1:0]  paddr,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [arc_pkg::APB_DW-1:0]  pwdata,
   output logic      [arc_pkg::APB_DW-1:0]  prdata,
   output logic                             pready,
   output logic                             pslverr,
   input  wire logic                        mains_ok,
   input  wire logic                        button,
   output logic                             run_out,
   output logic                             white_led,
   output logic                             beep_out,
   output logic                             filter_lamp,
   output logic      [arc_pkg::SET_W-1:0]   settings_out
);
   import arc_pkg::*;

   arc_nv_if nv ();

   arc_pwr_t              pw_reg;
   arc_seq_t              seq_reg;
   logic [MS_W-1:0]       pre_reg;
   logic                  ms_tick_reg;
   logic                  pready_reg;
   logic                  pslverr_reg;
   logic [APB_DW-1:0]     prdata_reg;
   logic [APB_DW-1:0]     rd_mux;
   arc_reg_t              sel;
   logic                  setup;
   logic                  acc_wr;
   logic                  wr_ctrl;
   logic                  wr_cfg;
   logic                  wr_stat;
   logic                  rem_on;
   logic                  rem_off;
   logic                  powered;
   logic                  loss;
   logic                  snap;
   logic [DLY_W-1:0]      dly_cnt_reg;
   logic                  dly_done;
   logic                  btn_prev_reg;
   logic                  press;
   logic                  release_ev;
   logic                  norm_press;
   logic                  hold_act_reg;
   logic [HOLD_W-1:0]     hold_cnt_reg;
   logic                  toggled_reg;
   logic                  hit_min;
   logic                  hit_max;
   logic                  revert;
   logic                  toggle_wr;
   logic                  running_reg;
   logic                  timer_reg;
   logic [SET_W-1:0]      settings_reg;
   logic                  set_dirty_reg;
   logic                  filter_lamp_reg;
   logic                  filter_req_reg;
   logic [SEQ_W-1:0]      seq_cnt_reg;
   logic [1:0]            beeps_left_reg;
   logic                  flash_after_reg;
   logic [BLK_W-1:0]      blk_cnt_reg;
   logic                  blink_reg;
   logic                  beep_reg;
   logic                  led_reg;
   logic                  restart_en;

   arc_nv_store u_store (
      .pclk          (pclk),
      .factory_rst_n (factory_rst_n),
      .nv            (nv)
   );

   // register index from byte address
   function automatic arc_reg_t decode(input logic [APB_AW-1:0] a);
      case (a)
         OFS_CTRL: decode = RG_CTRL;
         OFS_CFG:  decode = RG_CFG;
         OFS_STAT: decode = RG_STAT;
         default:  decode = RG_NONE;
      endcase
   endfunction

   // retained flag word from its three bits
   function automatic logic [NV_DW-1:0] flags_word(input logic en, input logic run, input logic tmr);
      flags_word             = '0;
      flags_word[NV_EN_BIT]  = en;
      flags_word[NV_RUN_BIT] = run;
      flags_word[NV_TMR_BIT] = tmr;
   endfunction

   assign restart_en = nv.rd_flags[NV_EN_BIT];

   // millisecond tick
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_reg     <= '0;
         ms_tick_reg <= 1'b0;
      end else if (pre_reg == MS_W'(CYC_PER_MS - 1)) begin
         pre_reg     <= '0;
         ms_tick_reg <= 1'b1;
      end else begin
         pre_reg     <= pre_reg + MS_W'(1);
         ms_tick_reg <= 1'b0;
      end
   end

   // apb decode and strobes
   assign sel     = decode(paddr);
   assign setup   = psel && !penable;
   assign acc_wr  = psel && penable && pwrite && pready_reg;
   assign wr_ctrl = acc_wr && (sel == RG_CTRL);
   assign wr_cfg  = acc_wr && (sel == RG_CFG);
   assign wr_stat = acc_wr && (sel == RG_STAT);
   assign rem_on  = wr_ctrl && pwdata[CTRL_ON_BIT] && powered;
   assign rem_off = wr_ctrl && pwdata[CTRL_OFF_BIT] && powered;

   // read data multiplexer
   always_comb begin
      rd_mux = '0;
      case (sel)
         RG_CFG: begin
            rd_mux[SET_W-1:0]  = settings_reg;
            rd_mux[CFG_FLT_BIT] = filter_lamp_reg;
         end
         RG_STAT: begin
            rd_mux[ST_RUN_BIT]   = running_reg;
            rd_mux[ST_EN_BIT]    = restart_en;
            rd_mux[ST_TMR_BIT]   = timer_reg;
            rd_mux[ST_PEND_BIT]  = (pw_reg == PW_DELAY);
            rd_mux[ST_FREQ_BIT]  = filter_req_reg;
            rd_mux[ST_MAINS_BIT] = mains_ok;
            rd_mux[ST_FLASH_BIT] = (seq_reg == SQ_FLASH);
            rd_mux[ST_BEEP_BIT]  = beep_reg;
         end
         default: rd_mux = '0;
      endcase
   end

   // apb answer: one access cycle, error on unmapped address
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= '0;
      end else begin
         pready_reg  <= setup;
         pslverr_reg <= setup && (sel == RG_NONE);
         if (setup && !pwrite) begin
            prdata_reg <= rd_mux;
         end
      end
   end

   // power presence
   assign powered  = (pw_reg == PW_ON) || (pw_reg == PW_DELAY);
   assign loss     = powered && !mains_ok;
   assign snap     = (pw_reg == PW_ON) && !mains_ok;
   assign dly_done = ms_tick_reg && (dly_cnt_reg == DLY_W'(RESTART_MS - 1));

   // power state: off, check retained flags, restart wait, on
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pw_reg <= PW_OFF;
      end else begin
         case (pw_reg)
            PW_OFF: begin
               if (mains_ok) pw_reg <= PW_CHECK;
            end
            PW_CHECK: begin
               if (!mains_ok) begin
                  pw_reg <= PW_OFF;
               end else if (restart_en && nv.rd_flags[NV_RUN_BIT] && !nv.rd_flags[NV_TMR_BIT]) begin
                  pw_reg <= PW_DELAY; // see RULE2 see RULE3 see RULE4 see RULE5
               end else begin
                  pw_reg <= PW_ON;
               end
            end
            PW_DELAY: begin
               if (!mains_ok) begin
                  pw_reg <= PW_OFF;
               end else if (dly_done || press || rem_on || rem_off) begin
                  pw_reg <= PW_ON;
               end
            end
            PW_ON: begin
               if (!mains_ok) pw_reg <= PW_OFF;
            end
            default: pw_reg <= PW_OFF;
         endcase
      end
   end

   // restart delay counter in milliseconds
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dly_cnt_reg <= '0;
      end else if (pw_reg != PW_DELAY) begin
         dly_cnt_reg <= '0;
      end else if (ms_tick_reg) begin
         dly_cnt_reg <= dly_cnt_reg + DLY_W'(1); // see RULE2
      end
   end

   // button press edge, ignored without mains; release edge taken regardless
   assign press      = button && !btn_prev_reg && powered && mains_ok;
   assign release_ev = !button && btn_prev_reg;
   assign norm_press = press && !filter_lamp_reg;
   assign hit_min    = hold_act_reg && ms_tick_reg && mains_ok && (hold_cnt_reg == HOLD_W'(LONG_MIN_MS));
   assign hit_max    = hold_act_reg && ms_tick_reg && (hold_cnt_reg == HOLD_W'(LONG_MAX_MS - 1));
   assign revert     = hit_max && toggled_reg && mains_ok;
   assign toggle_wr  = (hit_min || revert) && !snap;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         btn_prev_reg <= 1'b0;
      end else begin
         btn_prev_reg <= button;
      end
   end

   // hold time of a normal press
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_act_reg <= 1'b0;
         hold_cnt_reg <= '0;
         toggled_reg  <= 1'b0;
      end else if (loss || release_ev) begin
         hold_act_reg <= 1'b0;
      end else if (norm_press) begin
         hold_act_reg <= 1'b1;
         hold_cnt_reg <= '0;
         toggled_reg  <= 1'b0;
      end else if (hit_max) begin
         hold_act_reg <= 1'b0; // see RULE7
         toggled_reg  <= 1'b0;
      end else if (hold_act_reg && ms_tick_reg) begin
         hold_cnt_reg <= hold_cnt_reg + HOLD_W'(1);
         if (hit_min) toggled_reg <= 1'b1;
      end
   end

   // run state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         running_reg <= 1'b0;
      end else if (loss) begin
         running_reg <= 1'b0;
      end else if (pw_reg == PW_DELAY && dly_done) begin
         running_reg <= 1'b1; // see RULE2
      end else if (norm_press) begin
         running_reg <= !running_reg; // see RULE8 see RULE9 see RULE12
      end else if (rem_on) begin
         running_reg <= 1'b1;
      end else if (rem_off) begin
         running_reg <= 1'b0;
      end
   end

   // one-shot timer arming, discarded on loss
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_reg <= 1'b0;
      end else if (loss) begin
         timer_reg <= 1'b0; // see RULE14
      end else if (wr_ctrl && pwdata[CTRL_TARM_BIT]) begin
         timer_reg <= 1'b1;
      end else if (wr_ctrl && pwdata[CTRL_TCLR_BIT]) begin
         timer_reg <= 1'b0;
      end
   end

   // operating settings, restored from storage on power return
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         settings_reg  <= '0;
         set_dirty_reg <= 1'b0;
      end else begin
         if (pw_reg == PW_CHECK) begin
            settings_reg <= nv.rd_set[SET_W-1:0]; // see RULE16
         end else if (wr_cfg) begin
            settings_reg <= pwdata[SET_W-1:0];
         end
         if (wr_cfg) begin
            set_dirty_reg <= 1'b1;
         end else if (!snap && !toggle_wr) begin
            set_dirty_reg <= 1'b0;
         end
      end
   end

   // filter lamp and filter reset request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         filter_lamp_reg <= 1'b0;
         filter_req_reg  <= 1'b0;
      end else begin
         if (press && filter_lamp_reg) begin
            filter_lamp_reg <= 1'b0; // see RULE13
         end else if (wr_cfg) begin
            filter_lamp_reg <= pwdata[CFG_FLT_BIT];
         end
         if (press && filter_lamp_reg) begin
            filter_req_reg <= 1'b1; // see RULE13
         end else if (wr_stat && pwdata[ST_FREQ_BIT]) begin
            filter_req_reg <= 1'b0;
         end
      end
   end

   // retained storage writes: loss snapshot, then toggle, then settings
   always_comb begin
      nv.we    = 1'b0;
      nv.waddr = NV_FLAGS_ADDR;
      nv.wdata = nv.rd_flags;
      if (snap) begin
         nv.we    = 1'b1;
         nv.wdata = flags_word(restart_en, running_reg, timer_reg); // see RULE16 see RULE4 see RULE5
      end else if (toggle_wr) begin
         nv.we    = 1'b1; // see RULE6
         nv.wdata = flags_word(!restart_en, nv.rd_flags[NV_RUN_BIT], nv.rd_flags[NV_TMR_BIT]); // see RULE7
      end else if (set_dirty_reg) begin
         nv.we    = 1'b1;
         nv.waddr = NV_SET_ADDR;
         nv.wdata = {{(NV_DW - SET_W){1'b0}}, settings_reg};
      end
   end

   // beep and flash sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_reg         <= SQ_IDLE;
         seq_cnt_reg     <= '0;
         beeps_left_reg  <= '0;
         flash_after_reg <= 1'b0;
      end else if (loss) begin
         seq_reg         <= SQ_IDLE;
         flash_after_reg <= 1'b0;
      end else if (hit_min) begin
         seq_reg         <= SQ_BEEP_ON; // see RULE10
         seq_cnt_reg     <= '0;
         beeps_left_reg  <= 2'(BEEP_COUNT - 1);
         flash_after_reg <= !restart_en; // see RULE11
      end else if (revert) begin
         flash_after_reg <= 1'b0;
         if (seq_reg == SQ_FLASH) seq_reg <= SQ_IDLE;
      end else if (ms_tick_reg) begin
         seq_cnt_reg <= seq_cnt_reg + SEQ_W'(1);
         case (seq_reg)
            SQ_BEEP_ON: begin
               if (seq_cnt_reg == SEQ_W'(BEEP_ON_MS - 1)) begin
                  seq_reg     <= SQ_BEEP_OFF;
                  seq_cnt_reg <= '0;
               end
            end
            SQ_BEEP_OFF: begin
               if (seq_cnt_reg == SEQ_W'(BEEP_OFF_MS - 1)) begin
                  seq_cnt_reg <= '0;
                  if (beeps_left_reg != 2'b00) begin
                     seq_reg        <= SQ_BEEP_ON; // see RULE10
                     beeps_left_reg <= beeps_left_reg - 2'b01;
                  end else if (flash_after_reg) begin
                     seq_reg <= SQ_FLASH; // see RULE11
                  end else begin
                     seq_reg <= SQ_IDLE;
                  end
               end
            end
            SQ_FLASH: begin
               if (seq_cnt_reg == SEQ_W'(FLASH_MS - 1)) begin
                  seq_reg <= SQ_IDLE; // see RULE11
               end
            end
            default: seq_cnt_reg <= '0;
         endcase
      end
   end

   // blink phase while flashing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         blk_cnt_reg <= '0;
         blink_reg   <= 1'b0;
      end else if (seq_reg != SQ_FLASH) begin
         blk_cnt_reg <= '0;
         blink_reg   <= 1'b1;
      end else if (ms_tick_reg) begin
         if (blk_cnt_reg == BLK_W'(BLINK_HALF_MS - 1)) begin
            blk_cnt_reg <= '0;
            blink_reg   <= !blink_reg;
         end else begin
            blk_cnt_reg <= blk_cnt_reg + BLK_W'(1);
         end
      end
   end

   // registered lamp and beeper drive
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         beep_reg <= 1'b0;
         led_reg  <= 1'b0;
      end else begin
         beep_reg <= (seq_reg == SQ_BEEP_ON);
         led_reg  <= (seq_reg == SQ_FLASH) ? blink_reg : running_reg; // see RULE8 see RULE9
      end
   end

   assign prdata       = prdata_reg;
   assign pready       = pready_reg;
   assign pslverr      = pslverr_reg;
   assign run_out      = running_reg;
   assign white_led    = led_reg;
   assign beep_out     = beep_reg;
   assign filter_lamp  = filter_lamp_reg;
   assign settings_out = settings_reg;
endmodule

// *** bench/arc_auto_restart_monitor.sv ***
module arc_auto_restart_monitor
   import arc_pkg::*;
#(
   parameter int CYC_PER_MS = CYC_PER_MS_DFLT
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic mains_ok,
   input wire logic button,
   input wire logic run_out,
   input wire logic white_led,
   input wire logic beep_out,
   input wire logic filter_lamp
);
   int         on_cnt;
   logic [3:0] m_hist;
   // beep length and mains history
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         on_cnt <= 0;
         m_hist <= 4'h0;
      end else begin
         on_cnt <= beep_out ? on_cnt + 1 : 0;
         m_hist <= {m_hist[2:0], mains_ok};
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_press_starts: assert property (
      $rose(button) && &m_hist && !filter_lamp && !run_out |-> ##[1:2] run_out ##[0:2] white_led)
      else $error("press did not start unit");
   a_press_stops: assert property (
      $rose(button) && &m_hist && !filter_lamp && run_out |-> ##[1:2] !run_out ##[0:2] !white_led)
      else $error("press did not stop unit");
   a_filter_clear: assert property (
      $rose(button) && mains_ok && filter_lamp |-> ##[1:3] !filter_lamp)
      else $error("filter lamp not cleared");
   a_filter_run: assert property (
      $rose(button) && &m_hist && filter_lamp |=> $stable(run_out)[*3])
      else $error("filter reset changed run state");
   a_run_holds: assert property (
      run_out && !button && !$past(button) && !$past(button, 2) && !psel && !$past(psel)
      |=> run_out || !mains_ok)
      else $error("run state dropped by itself");
   a_no_mains: assert property (
      !mains_ok && !$past(mains_ok) |-> !run_out)
      else $error("unit runs without mains");
   a_beep_len: assert property (
      $fell(beep_out) |-> on_cnt inside {[BEEP_ON_MS * CYC_PER_MS - 1 : BEEP_ON_MS * CYC_PER_MS + 1]})
      else $error("beep length wrong");
   a_apb_ready: assert property (
      psel && penable |-> pready)
      else $error("apb access without ready");
endmodule

bind arc_auto_restart arc_auto_restart_monitor #(.CYC_PER_MS(CYC_PER_MS)) mon_u (.*);

// *** bench/arc_panel_model.sv ***
module arc_panel_model (
   input wire logic        pclk,
   input wire logic        go,
   input wire logic [15:0] hold,
   output logic            button
);
   timeunit 1ns;
   timeprecision 1ns;
   int left = 0;
   initial button = 1'b0;
   // operator holds the button for the asked cycles
   always @(posedge pclk) begin
      if (go && left == 0) begin
         left <= int'(hold);
         button <= 1'b1;
      end else if (left > 1) begin
         left <= left - 1;
      end else begin
         left <= 0;
         button <= 1'b0;
      end
   end
endmodule

// *** bench/arc_auto_restart_tb_top.sv ***
`define CHK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin bad_count++; \
   $display("ERROR %s expected %0h seen %0h", what, exp, got); end end
module arc_auto_restart_tb_top
   import arc_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int CPM = 1;
   logic              pclk = 0, presetn = 0, frst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic              mains_ok = 1, go = 0, err, beep_q = 0, led_q = 0;
   logic              pready, pslverr, button, run_out, white_led, beep_out, filter_lamp;
   logic [APB_AW-1:0] paddr = '0;
   logic [APB_DW-1:0] pwdata = '0, prdata, rd;
   logic [15:0]       hold = '0;
   logic [7:0]        s;
   logic [SET_W-1:0]  settings_out;
   int                bad_count = 0, check_count = 0, cyc = 0, beeps = 0, flashes = 0;
   int                seed = 32'h8245D1DC;

   arc_auto_restart #(.CYC_PER_MS(CPM)) dut_u (.pclk(pclk), .presetn(presetn), .factory_rst_n(frst_n),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .mains_ok(mains_ok), .button(button), .run_out(run_out),
      .white_led(white_led), .beep_out(beep_out), .filter_lamp(filter_lamp), .settings_out(settings_out));
   arc_panel_model panel_u (.pclk(pclk), .go(go), .hold(hold), .button(button));

   always #25 pclk = ~pclk;
   // beep and blink counting, hang guard
   always @(posedge pclk) begin
      beep_q <= beep_out;
      led_q <= white_led;
      beeps += int'(beep_out & !beep_q);
      flashes += int'(led_q & !white_led);
      cyc++;
      if (cyc > 60000) begin
         bad_count++;
         stop_test();
      end
   end

   function automatic logic exp_pend(logic en, logic run, logic tmr);
      return en & run & !tmr;
   endfunction

   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [APB_DW-1:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic press(input int ms, input int after);
      hold <= 16'(ms * CPM);
      go <= 1'b1;
      @(posedge pclk) go <= 1'b0;
      repeat (ms * CPM + after) @(posedge pclk);
   endtask

   // every run and timer state through a mains loss
   task automatic outage(input logic en);
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, OFS_CTRL, {28'h0, i[0] ? 2'b01 : 2'b10, i[1] ? 2'b01 : 2'b10});
         mains_ok <= 1'b0;
         repeat (5) @(posedge pclk);
         mains_ok <= 1'b1;
         repeat (5) @(posedge pclk);
         apb(1'b0, OFS_STAT, '0);
         `CHK("pending", exp_pend(en, i[1], i[0]), rd[ST_PEND_BIT])
         `CHK("timer", 1'b0, rd[ST_TMR_BIT])
         `CHK("early run", 1'b0, run_out)
         apb(1'b1, OFS_CTRL, 32'h2);
      end
   endtask

   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      frst_n <= 1'b1;
      repeat (2) @(posedge pclk);
      apb(1'b0, OFS_STAT, '0);
      `CHK("factory", 2'b10, rd[1:0])
      for (int i = 0; i < 3; i++) begin
         s = 8'($random(seed));
         apb(1'b1, OFS_CFG, {24'h0, s});
         apb(1'b0, OFS_CFG, '0);
         `CHK("cfg", {24'h0, s}, rd)
         `CHK("set out", s, settings_out)
      end
      apb(1'b0, 8'h0C, '0);
      `CHK("unmapped", 33'h100000000, {err, rd})
      press(50 + {$random(seed)} % 100, 5);
      `CHK("start", 2'b11, {run_out, white_led})
      press(50 + {$random(seed)} % 100, 5);
      `CHK("stop", 2'b00, {run_out, white_led})
      apb(1'b0, OFS_STAT, '0);
      `CHK("short", 2'b10, rd[1:0])
      beeps = 0;
      flashes = 0;
      press(4000, 1500);
      apb(1'b0, OFS_STAT, '0);
      `CHK("disable", 2'b01, rd[1:0])
      `CHK("beeps", 3, beeps)
      `CHK("no flash", 0, flashes)
      presetn <= 1'b0;
      @(posedge pclk) presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      apb(1'b0, OFS_STAT, '0);
      `CHK("kept", 1'b0, rd[ST_EN_BIT])
      `CHK("set kept", s, settings_out)
      outage(1'b0);
      beeps = 0;
      flashes = 0;
      press(4000, 6500);
      apb(1'b0, OFS_STAT, '0);
      `CHK("enable", 2'b11, rd[1:0])
      `CHK("beeps", 3, beeps)
      `CHK("flash", 1'b1, flashes >= 9 && flashes <= 11)
      outage(1'b1);
      beeps = 0;
      press(10500, 1500);
      apb(1'b0, OFS_STAT, '0);
      `CHK("too long", 2'b11, rd[1:0])
      `CHK("beeps", 3, beeps)
      mains_ok <= 1'b0;
      beeps = 0;
      press(4000, 100);
      mains_ok <= 1'b1;
      repeat (5) @(posedge pclk);
      apb(1'b0, OFS_STAT, '0);
      `CHK("unpowered", 3'b110, {beeps == 0, rd[1:0]})
      apb(1'b1, OFS_CFG, 32'h100);
      `CHK("lamp", 1'b1, filter_lamp)
      press(100, 5);
      apb(1'b0, OFS_STAT, '0);
      `CHK("filter", 3'b010, {filter_lamp, rd[ST_FREQ_BIT], run_out})
      apb(1'b1, OFS_STAT, 32'h10);
      apb(1'b0, OFS_STAT, '0);
      `CHK("filter clr", 1'b0, rd[ST_FREQ_BIT])
      stop_test();
   end
endmodule
